// *** hdl/snaddr_top.sv ***
// Summary of operation
// - Addresses are grouped by device class; reserved ranges are never probed.
// - A scan request walks all addresses, probing and reporting each non-reserved one.
// - Detected devices hold status OK, error or trouble; undetected hold none.
// - Each device keeps an error count readable while browsing.
// - Any detected device that stops answering raises network trouble.
// - Every fault, trouble and restoral produces one event log entry.
// - Zone expander at 48 owns points 1-10, each next address ten more.
// - Loop modules 64-69 each own two circuits of points 1-126.
// - Loop module switches: none gives 64, then 65, 66, 67.
// - Zone expander switches: relays, per-zone, unit two, scheme, address.
// - Relay count: off 0; else 1 or 2 five-zone, 2 or 4 ten-zone.
// - Zone expander switches are sampled once after power-up, continually if ZX_ON_THE_FLY is set.
// - Zone expander address is 48 plus switches 5-8, switch 5 lowest; 0 while switch 4 is off.
// - LED driver address from switches 1-4; switch 7 enables drill.
// - LED driver switches 5 and 6 enable local and global silence.
// - LED driver switch 8 enables its reset input to reset everything.
// - Display annunciator reports comm failure after 15 s until addressed.
// - City box switch 1: off is 11 general alarm, on 12 waterflow.
// - City box switch 2: off polarity reversing, on city tie box.
// - Panel bridge address from switches 0-4; switch 5 unused.
// - Driver variant panel bridge: switch 6 global silence, 7 global reset.
// - Each LED driver holds a base LED number set by software.
`timescale 1ns/100ps
`default_nettype none
module snaddr_top #(
  parameter int unsigned DISP_FAIL_CYCLES = snaddr_pkg::DISP_FAIL_S * snaddr_pkg::CLK_HZ,
  parameter bit ZX_ON_THE_FLY = 1'b0
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [31:0] reg_rdata_o,
  output logic probe_req_o,
  output logic [7:0] probe_addr_o,
  input wire logic resp_i,
  input wire logic [7:0] zx_sw_i,
  input wire logic zx_ten_i,
  output logic [31:0] zx_cfg_o,
  output logic scan_busy_o,
  output logic [7:0] scan_addr_o,
  output logic net_trouble_o,
  output logic log_valid_o,
  output logic [1:0] log_code_o,
  output logic [7:0] log_addr_o,
  output logic disp_fail_o
);

  typedef struct packed {
    snaddr_pkg::snaddr_state_t state;
    logic scanning;
    logic poll_en;
    logic [7:0] addr;
    logic [15:0] timer;
    logic probe_req;
    logic [255:0] det;
    logic [255:0][1:0] stat;
    logic [255:0][7:0] err;
    logic [255:0][1:0] miss;
    logic trouble;
    logic log_v;
    logic [1:0] log_code;
    logic [7:0] log_addr;
    logic [31:0] rdata;
    logic [7:0] sel;
    logic [15:0][7:0] ledbase;
    logic [31:0] dec;
    logic [27:0] disp_cnt;
    logic disp_fail;
    logic disp_named;
    logic resp_s1;
    logic resp_s2;
    logic [8:0] zx_s1;
    logic [8:0] zx_s2;
    logic [1:0] settle;
    logic zx_taken;
    logic [31:0] zx_cfg;
  } snaddr_state_s_t;

  snaddr_state_s_t q;
  snaddr_state_s_t d;

  // Device class of a network address
  // class ranges
  function automatic logic [3:0] dev_class(input logic [7:0] a);
    logic [3:0] c;
    c = snaddr_pkg::C_RSVD;
    if (a == snaddr_pkg::A_DIALER)
      c = snaddr_pkg::C_DIALER;
    else if (a == snaddr_pkg::A_CITY_GA || a == snaddr_pkg::A_CITY_WF)
      c = snaddr_pkg::C_CITY;
    else if (a >= snaddr_pkg::A_LED_LO && a <= snaddr_pkg::A_LED_HI)
      c = snaddr_pkg::C_LED;
    else if (a >= snaddr_pkg::A_DISP_LO && a <= snaddr_pkg::A_DISP_HI)
      c = snaddr_pkg::C_DISP;
    else if (a >= snaddr_pkg::A_ZX_LO && a <= snaddr_pkg::A_ZX_HI)
      c = snaddr_pkg::C_ZX;
    else if (a >= snaddr_pkg::A_LOOP_LO && a <= snaddr_pkg::A_LOOP_HI)
      c = snaddr_pkg::C_LOOP;
    else if (a > snaddr_pkg::A_LOOP_HI && a <= snaddr_pkg::A_FUT1_HI)
      c = snaddr_pkg::C_FUTURE;
    else if (a >= snaddr_pkg::A_BR_LO && a <= snaddr_pkg::A_BR_HI)
      c = snaddr_pkg::C_BRIDGE;
    else if (a > snaddr_pkg::A_BR_HI && a <= snaddr_pkg::A_FUT2_HI)
      c = snaddr_pkg::C_FUTURE;
    else if (a >= snaddr_pkg::A_DIO_LO && a <= snaddr_pkg::A_DIO_HI)
      c = snaddr_pkg::C_DIO;
    else if (a > snaddr_pkg::A_DIO_HI && a <= snaddr_pkg::A_FUT3_HI)
      c = snaddr_pkg::C_FUTURE;
    return c;
  endfunction

  // Switch bank decode per module type; sw[n-1] is switch n except bridges
  function automatic logic [31:0] dec_sw(input logic [2:0] k, input logic [7:0] sw);
    logic [7:0] a;
    logic [7:0] first;
    logic [2:0] rel;
    logic [31:0] r;
    a = 8'h00;
    first = 8'h00;
    rel = 3'h0;
    r = 32'h0000_0000;
    case (k)
      snaddr_pkg::DC_FIVE, snaddr_pkg::DC_TEN:
      begin
        a = sw[3] ? 8'(snaddr_pkg::A_ZX_LO + {4'h0, sw[7:4]}) : 8'h00;
        first = 8'({4'h0, sw[7:4]} * snaddr_pkg::ZX_PTS_PER + snaddr_pkg::FIRST_ONE);
        if (!sw[0])
          rel = 3'h0;
        else if (k == snaddr_pkg::DC_TEN)
          rel = sw[1] ? 3'h4 : 3'h2;
        else
          rel = sw[1] ? 3'h2 : 3'h1;
        // unit two flag ignored on ten-zone
        r = {(k == snaddr_pkg::DC_TEN) ? snaddr_pkg::TEN_PTS : snaddr_pkg::FIVE_PTS, first,
             sw[2] & (k == snaddr_pkg::DC_FIVE), rel, 7'h00, sw[1], a};
      end
      snaddr_pkg::DC_LOOP:
      begin
        a = 8'(snaddr_pkg::A_LOOP_LO + {6'h00, sw[1:0]});
        first = 8'({6'h00, sw[1:0]} * 8'h02 + snaddr_pkg::FIRST_ONE);
        r = {snaddr_pkg::LOOP_CIRCS, first, 4'h0, snaddr_pkg::LOOP_PTS, a};
      end
      snaddr_pkg::DC_LED:
      begin
        a = 8'(snaddr_pkg::A_LED_LO + {4'h0, sw[3:0]});
        r = {20'h00000, sw[7], sw[6], sw[5], sw[4], a};
      end
      snaddr_pkg::DC_CITY:
      begin
        a = sw[0] ? snaddr_pkg::A_CITY_WF : snaddr_pkg::A_CITY_GA;
        r = {22'h000000, sw[1], sw[0], a};
      end
      snaddr_pkg::DC_BR, snaddr_pkg::DC_BRDRV:
      begin
        a = 8'(snaddr_pkg::A_BR_LO + {3'h0, sw[4:0]});
        r = {22'h000000, sw[7] & (k == snaddr_pkg::DC_BRDRV),
             sw[6] & (k == snaddr_pkg::DC_BRDRV), a};
      end
      default:
      begin
        r = 32'h0000_0000;
      end
    endcase
    return r;
  endfunction

  // Next state of the whole block
  always_comb
  begin
    logic any_trb;
    logic [1:0] m;
    any_trb = 1'b0;
    m = 2'h0;
    d = q;
    if (ce_i)
    begin
      // Pin synchronisers
      d.resp_s1 = resp_i;
      d.resp_s2 = q.resp_s1;
      d.zx_s1 = {zx_ten_i, zx_sw_i};
      d.zx_s2 = q.zx_s1;
      d.log_v = 1'b0;
      d.rdata = 32'h0000_0000;
      if (q.settle != snaddr_pkg::SYNC_SETTLE)
        d.settle = 2'(q.settle + 2'h1);
      else if (!q.zx_taken || ZX_ON_THE_FLY)
      begin
        d.zx_taken = 1'b1;
        d.zx_cfg = dec_sw(q.zx_s2[8] ? snaddr_pkg::DC_TEN : snaddr_pkg::DC_FIVE, q.zx_s2[7:0]);
      end
      if (q.disp_named)
        d.disp_fail = 1'b0;
      else if (q.disp_cnt == 28'(DISP_FAIL_CYCLES - 1))
        d.disp_fail = 1'b1;
      else
        d.disp_cnt = 28'(q.disp_cnt + 28'h1);
      // Probe sequencer
      case (q.state)
        snaddr_pkg::S_IDLE:
        begin
          if (q.scanning || q.poll_en)
            d.state = snaddr_pkg::S_PROBE;
        end
        snaddr_pkg::S_PROBE:
        begin
          if (q.scanning ? (dev_class(q.addr) != snaddr_pkg::C_RSVD) : q.det[q.addr])
          begin
            d.probe_req = 1'b1;
            d.timer = snaddr_pkg::PROBE_TO;
            d.state = snaddr_pkg::S_WAIT;
          end
          else
            d.state = snaddr_pkg::S_STEP;
        end
        snaddr_pkg::S_WAIT:
        begin
          d.probe_req = 1'b0;
          if (q.resp_s2)
          begin
            if (q.det[q.addr] && q.stat[q.addr] != snaddr_pkg::ST_OK)
            begin
              d.log_v = 1'b1;
              d.log_code = snaddr_pkg::LOG_RESTORE;
              d.log_addr = q.addr;
            end
            d.det[q.addr] = 1'b1;
            d.stat[q.addr] = snaddr_pkg::ST_OK;
            d.miss[q.addr] = 2'h0;
            d.state = snaddr_pkg::S_STEP;
          end
          else if (q.timer == 16'h0000)
          begin
            if (q.det[q.addr])
            begin
              if (q.err[q.addr] != snaddr_pkg::ERR_MAX)
                d.err[q.addr] = 8'(q.err[q.addr] + 8'h01);
              m = (q.miss[q.addr] == snaddr_pkg::MISS_LIMIT) ? q.miss[q.addr] :
                  2'(q.miss[q.addr] + 2'h1);
              d.miss[q.addr] = m;
              if (m == snaddr_pkg::MISS_LIMIT && q.stat[q.addr] != snaddr_pkg::ST_TRB)
              begin
                d.stat[q.addr] = snaddr_pkg::ST_TRB;
                d.log_v = 1'b1;
                d.log_code = snaddr_pkg::LOG_TROUBLE;
                d.log_addr = q.addr;
              end
              else if (q.stat[q.addr] == snaddr_pkg::ST_OK)
              begin
                d.stat[q.addr] = snaddr_pkg::ST_ERR;
                d.log_v = 1'b1;
                d.log_code = snaddr_pkg::LOG_FAULT;
                d.log_addr = q.addr;
              end
            end
            d.state = snaddr_pkg::S_STEP;
          end
          else
            d.timer = 16'(q.timer - 16'h0001);
        end
        default:
        begin
          d.addr = 8'(q.addr + 8'h01);
          if (q.scanning && q.addr == snaddr_pkg::A_LAST)
          begin
            d.scanning = 1'b0;
            d.state = snaddr_pkg::S_IDLE;
          end
          else
            d.state = (q.scanning || q.poll_en) ? snaddr_pkg::S_PROBE : snaddr_pkg::S_IDLE;
        end
      endcase
      for (int i = 0; i < 256; i++)
        any_trb = any_trb | (d.stat[i] == snaddr_pkg::ST_TRB);
      d.trouble = any_trb;
      // Register writes
      if (reg_we_i)
      begin
        if (reg_addr_i == snaddr_pkg::R_CTRL)
        begin
          d.poll_en = reg_wdata_i[1];
          if (reg_wdata_i[0] && !q.scanning)
          begin
            d.scanning = 1'b1;
            d.addr = 8'h00;
            d.probe_req = 1'b0;
            d.state = snaddr_pkg::S_PROBE;
          end
        end
        else if (reg_addr_i == snaddr_pkg::R_SEL)
          d.sel = reg_wdata_i[7:0];
        else if (reg_addr_i == snaddr_pkg::R_DECODE)
          d.dec = dec_sw(reg_wdata_i[10:8], reg_wdata_i[7:0]);
        else if (reg_addr_i == snaddr_pkg::R_LEDBASE)
          d.ledbase[q.sel[3:0]] = reg_wdata_i[7:0];
        else if (reg_addr_i == snaddr_pkg::R_DISPADDR)
          d.disp_named = (reg_wdata_i[7:0] >= snaddr_pkg::A_DISP_LO) &&
                         (reg_wdata_i[7:0] <= snaddr_pkg::A_DISP_HI);
      end
      // Register reads, data in the next cycle only
      if (reg_re_i)
      begin
        if (reg_addr_i == snaddr_pkg::R_CTRL)
          d.rdata = {30'h00000000, q.poll_en, q.scanning};
        else if (reg_addr_i == snaddr_pkg::R_STATUS)
          d.rdata = {16'h0000, q.addr, 5'h00, q.disp_fail, q.trouble, q.scanning};
        else if (reg_addr_i == snaddr_pkg::R_SEL)
          d.rdata = {24'h000000, q.sel};
        else if (reg_addr_i == snaddr_pkg::R_DEVINFO)
          d.rdata = {12'h000, dev_class(q.sel), q.err[q.sel], 5'h00, q.stat[q.sel], q.det[q.sel]};
        else if (reg_addr_i == snaddr_pkg::R_DECODE)
          d.rdata = q.dec;
        else if (reg_addr_i == snaddr_pkg::R_LEDBASE)
          d.rdata = {24'h000000, q.ledbase[q.sel[3:0]]};
        else if (reg_addr_i == snaddr_pkg::R_DISPADDR)
          d.rdata = {31'h00000000, q.disp_named};
        else if (reg_addr_i == snaddr_pkg::R_ZXCFG)
          d.rdata = q.zx_cfg;
        else
          d.rdata = 32'h0000_0000;
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      q <= '0;
    else
      q <= d;
  end

  // Outputs straight from state
  assign reg_rdata_o = q.rdata;
  assign probe_req_o = q.probe_req;
  assign probe_addr_o = q.addr;
  assign zx_cfg_o = q.zx_cfg;
  assign scan_busy_o = q.scanning;
  assign scan_addr_o = q.addr;
  assign net_trouble_o = q.trouble;
  assign log_valid_o = q.log_v;
  assign log_code_o = q.log_code;
  assign log_addr_o = q.log_addr;
  assign disp_fail_o = q.disp_fail;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence probe_issued;
    probe_req_o && ce_i;
  endsequence

  scan_step_a: assert property (q.state == snaddr_pkg::S_STEP && q.scanning && ce_i && !reg_we_i
    |=> q.addr == 8'($past(q.addr) + 8'h01)) else $error("scan did not advance");
  rsvd_probe_a: assert property (probe_req_o |-> dev_class(probe_addr_o) != snaddr_pkg::C_RSVD
    || q.det[probe_addr_o]) else $error("reserved address probed");
  stat_det_a: assert property (!q.det[q.sel] |-> q.stat[q.sel] == snaddr_pkg::ST_OK)
    else $error("status without detection");
  trb_log_a: assert property (log_valid_o && log_code_o == snaddr_pkg::LOG_TROUBLE
    |-> net_trouble_o) else $error("trouble logged without net trouble");
  probe_wait_a: assert property (probe_issued |=> !probe_req_o ##0
    (q.state == snaddr_pkg::S_WAIT || $past(reg_we_i))) else $error("probe not single");
  zx_hold_a: assert property (q.zx_taken && !ZX_ON_THE_FLY |=> $stable(zx_cfg_o))
    else $error("zone expander config changed");
  // failure rises at the timer end
  disp_rise_a: assert property ($rose(disp_fail_o) |-> $past(q.disp_cnt) ==
    28'(DISP_FAIL_CYCLES - 1)) else $error("display failure timing");
  loop_dec_a: assert property (ce_i && reg_we_i && reg_addr_i == snaddr_pkg::R_DECODE &&
    reg_wdata_i[10:0] == {snaddr_pkg::DC_LOOP, 8'h00} |=> q.dec[7:0] == snaddr_pkg::A_LOOP_LO)
    else $error("loop module decode");
  relay_dec_a: assert property (ce_i && reg_we_i && reg_addr_i == snaddr_pkg::R_DECODE &&
    reg_wdata_i[10:0] == {snaddr_pkg::DC_TEN, 8'h03} |=> q.dec[18:16] == 3'h4)
    else $error("relay count decode");
  // Read data stands one cycle
  rd_once_a: assert property (ce_i && !reg_re_i |=> reg_rdata_o == 32'h0000_0000)
    else $error("read data held");

endmodule
`default_nettype wire

// *** inc/snaddr_pkg.sv ***
`default_nettype none
package snaddr_pkg;
  // Clock and timing
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned PROBE_TO_US = 100;
  localparam int unsigned PROBE_TO_CYC = (PROBE_TO_US * (CLK_HZ / 1_000_000));
  localparam int unsigned DISP_FAIL_S = 15;
  localparam logic [15:0] PROBE_TO = 16'(PROBE_TO_CYC - 1);
  localparam logic [1:0] MISS_LIMIT = 2'h3;
  localparam logic [1:0] SYNC_SETTLE = 2'h3;
  localparam logic [7:0] ERR_MAX = 8'hff;
  // Network address plan
  localparam logic [7:0] A_DIALER = 8'h0a;
  localparam logic [7:0] A_CITY_GA = 8'h0b;
  localparam logic [7:0] A_CITY_WF = 8'h0c;
  localparam logic [7:0] A_LED_LO = 8'h10;
  localparam logic [7:0] A_LED_HI = 8'h1f;
  localparam logic [7:0] A_DISP_LO = 8'h20;
  localparam logic [7:0] A_DISP_HI = 8'h2f;
  localparam logic [7:0] A_ZX_LO = 8'h30;
  localparam logic [7:0] A_ZX_HI = 8'h3b;
  localparam logic [7:0] A_LOOP_LO = 8'h40;
  localparam logic [7:0] A_LOOP_HI = 8'h45;
  localparam logic [7:0] A_FUT1_HI = 8'h4f;
  localparam logic [7:0] A_BR_LO = 8'h50;
  localparam logic [7:0] A_BR_HI = 8'h6f;
  localparam logic [7:0] A_FUT2_HI = 8'h7f;
  localparam logic [7:0] A_DIO_LO = 8'h80;
  localparam logic [7:0] A_DIO_HI = 8'hbf;
  localparam logic [7:0] A_FUT3_HI = 8'hfa;
  localparam logic [7:0] A_LAST = 8'hff;
  // Device classes
  localparam logic [3:0] C_RSVD = 4'h0;
  localparam logic [3:0] C_DIALER = 4'h1;
  localparam logic [3:0] C_CITY = 4'h2;
  localparam logic [3:0] C_LED = 4'h3;
  localparam logic [3:0] C_DISP = 4'h4;
  localparam logic [3:0] C_ZX = 4'h5;
  localparam logic [3:0] C_LOOP = 4'h6;
  localparam logic [3:0] C_FUTURE = 4'h7;
  localparam logic [3:0] C_BRIDGE = 4'h8;
  localparam logic [3:0] C_DIO = 4'h9;
  // Switch decode selectors
  localparam logic [2:0] DC_FIVE = 3'h0;
  localparam logic [2:0] DC_TEN = 3'h1;
  localparam logic [2:0] DC_LOOP = 3'h2;
  localparam logic [2:0] DC_LED = 3'h3;
  localparam logic [2:0] DC_CITY = 3'h4;
  localparam logic [2:0] DC_BR = 3'h5;
  localparam logic [2:0] DC_BRDRV = 3'h6;
  // Point figures
  localparam logic [7:0] ZX_PTS_PER = 8'h0a;
  localparam logic [3:0] FIVE_PTS = 4'h5;
  localparam logic [3:0] TEN_PTS = 4'ha;
  localparam logic [7:0] LOOP_PTS = 8'h7e;
  localparam logic [3:0] LOOP_CIRCS = 4'h2;
  localparam logic [7:0] FIRST_ONE = 8'h01;
  // Comm status and log codes
  localparam logic [1:0] ST_OK = 2'h0;
  localparam logic [1:0] ST_ERR = 2'h1;
  localparam logic [1:0] ST_TRB = 2'h2;
  localparam logic [1:0] LOG_FAULT = 2'h1;
  localparam logic [1:0] LOG_TROUBLE = 2'h2;
  localparam logic [1:0] LOG_RESTORE = 2'h3;
  // Register byte offsets
  localparam logic [7:0] R_CTRL = 8'h00;
  localparam logic [7:0] R_STATUS = 8'h04;
  localparam logic [7:0] R_SEL = 8'h08;
  localparam logic [7:0] R_DEVINFO = 8'h0c;
  localparam logic [7:0] R_DECODE = 8'h10;
  localparam logic [7:0] R_LEDBASE = 8'h14;
  localparam logic [7:0] R_DISPADDR = 8'h18;
  localparam logic [7:0] R_ZXCFG = 8'h1c;
  // Sequencer states
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_PROBE = 2'b01,
    S_WAIT = 2'b10,
    S_STEP = 2'b11
  } snaddr_state_t;
endpackage
`default_nettype wire

// *** sim/serial_network_addressing_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) \
  begin \
    tests_run++; \
    if ((a) !== (e)) \
    begin \
      failures++; \
      $display("[ERR] %s exp %h got %h", n, e, a); \
    end \
  end
module serial_network_addressing_bench;
  logic clk, rst, ce, we, re, resp, zten, preq, busy, ntrb, lvalid, dfail;
  logic [7:0] addr, zsw, paddr, saddr, laddr, drop;
  logic [31:0] wdata, rdata, zcfg;
  logic [1:0] lcode;
  int failures, tests_run, probes, rsvd;

  snaddr_top #(.DISP_FAIL_CYCLES(50)) uut (.ref_clk_i(clk), .rst_i(rst), .ce_i(ce),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re),
    .reg_rdata_o(rdata), .probe_req_o(preq), .probe_addr_o(paddr), .resp_i(resp),
    .zx_sw_i(zsw), .zx_ten_i(zten), .zx_cfg_o(zcfg), .scan_busy_o(busy),
    .scan_addr_o(saddr), .net_trouble_o(ntrb), .log_valid_o(lvalid),
    .log_code_o(lcode), .log_addr_o(laddr), .disp_fail_o(dfail));
  snaddr_partner far (.clk_i(clk), .rst_i(rst), .req_i(preq), .addr_i(paddr),
    .drop_i(drop), .resp_o(resp), .probes_o(probes), .rsvd_o(rsvd));

  // Free-running clock
  always #50 clk = ~clk;

  // Register access, one-cycle strobes
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic dev(input logic [7:0] i, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    wr(snaddr_pkg::R_SEL, {24'h0, i});
    rd(snaddr_pkg::R_DEVINFO, d);
    `CHK("devinfo", e, d & m)
  endtask
  task automatic wait_log(input logic [1:0] c, input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    while (lvalid !== 1'b1 && n < 20000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK("log seen", 1'b1, lvalid)
    `CHK("log code", c, lcode)
    `CHK("log addr", a, laddr)
  endtask

  // Strap captured once after power-up
  task automatic t_strap();
    repeat (10) @(posedge clk);
    #1;
    `CHK("zx cfg", 32'ha0b2_0031, zcfg)
    zsw <= 8'h00;
    repeat (10) @(posedge clk);
    #1;
    `CHK("zx hold", 32'ha0b2_0031, zcfg)
  endtask

  // Display annunciator fail until addressed
  task automatic t_disp();
    logic [31:0] d;
    repeat (60) @(posedge clk);
    #1;
    `CHK("disp fail", 1'b1, dfail)
    wr(snaddr_pkg::R_DISPADDR, 32'h0000_0020);
    repeat (2) @(posedge clk);
    #1;
    `CHK("disp ok", 1'b0, dfail)
    rd(snaddr_pkg::R_DISPADDR, d);
    `CHK("disp named", 32'h1, d)
  endtask

  // Switch decode table: kind and switches, mask, expected
  task automatic t_decode();
    logic [31:0] d;
    logic [10:0] c[13] = '{11'h201, 11'h203, 11'h3a5, 11'h34a, 11'h401,
      11'h402, 11'h6e3, 11'h5e3, 11'h02b, 11'h11f, 11'h200, 11'h103, 11'h00d};
    logic [31:0] m[13] = '{32'hffffffff, 32'hff, 32'hf0f, 32'hf0f, 32'hffffffff,
      32'hffffffff, 32'hffffffff, 32'hffffffff, 32'hffffffff, 32'hffffffff,
      32'hffffffff, 32'hffffffff, 32'hffffffff};
    logic [31:0] e[13] = '{32'h2030_7e41, 32'h43, 32'ha05, 32'h40a, 32'h10c,
      32'h20b, 32'h353, 32'h53, 32'h5152_0132, 32'ha0b4_0131, 32'h2010_7e40,
      32'ha014_0100, 32'h5019_0030};
    for (int i = 0; i < 13; i++)
    begin
      wr(snaddr_pkg::R_DECODE, {21'h0, c[i]});
      rd(snaddr_pkg::R_DECODE, d);
      `CHK("decode", e[i], d & m[i])
    end
    // Base LED numbers kept per driver index
    wr(snaddr_pkg::R_SEL, 32'h0000_0013);
    wr(snaddr_pkg::R_LEDBASE, 32'h0000_001f);
    wr(snaddr_pkg::R_SEL, 32'h0000_0002);
    wr(snaddr_pkg::R_LEDBASE, 32'h0000_0005);
    rd(snaddr_pkg::R_LEDBASE, d);
    `CHK("led base two", 32'h5, d)
    wr(snaddr_pkg::R_SEL, 32'h0000_0003);
    rd(snaddr_pkg::R_LEDBASE, d);
    `CHK("led base three", 32'h1f, d)
    rd(snaddr_pkg::R_ZXCFG, d);
    `CHK("zx cfg reg", 32'ha0b2_0031, d)
  endtask

  // Full scan with two absent modules
  task automatic t_scan();
    int n;
    logic [7:0] top;
    logic [31:0] d;
    logic [7:0] a[6] = '{8'h30, 8'h31, 8'h05, 8'h0a, 8'h80, 8'h48};
    logic [31:0] m[6] = '{32'hfffff, 32'h1, 32'hf0001, 32'hf0001, 32'hf0007, 32'hf0000};
    logic [31:0] e[6] = '{32'h50001, 32'h0, 32'h0, 32'h10000, 32'h90001, 32'h70000};
    wr(snaddr_pkg::R_CTRL, 32'h1);
    n = 0;
    top = 8'h00;
    repeat (3) @(posedge clk);
    #1;
    while (busy !== 1'b0 && n < 20000)
    begin
      if (saddr > top)
        top = saddr;
      @(posedge clk);
      #1;
      n++;
    end
    `CHK("scan done", 1'b0, busy)
    `CHK("scan reach", 8'hff, top)
    `CHK("scan wrap", 8'h00, saddr)
    `CHK("probes", 234, probes)
    `CHK("reserved", 0, rsvd)
    for (int i = 0; i < 6; i++)
      dev(a[i], m[i], e[i]);
    rd(snaddr_pkg::R_STATUS, d);
    `CHK("status idle", 32'h0, d)
  endtask

  // Poll, lose a device, then restore it
  task automatic t_poll();
    logic [31:0] d;
    wr(snaddr_pkg::R_CTRL, 32'h2);
    drop <= 8'h30;
    wait_log(snaddr_pkg::LOG_FAULT, 8'h30);
    wait_log(snaddr_pkg::LOG_TROUBLE, 8'h30);
    `CHK("net trouble", 1'b1, ntrb)
    rd(snaddr_pkg::R_STATUS, d);
    `CHK("status trouble", 32'h2, d & 32'h7)
    rd(snaddr_pkg::R_CTRL, d);
    `CHK("ctrl poll", 32'h2, d)
    dev(8'h30, 32'hfffff, 32'h50305);
    drop <= 8'h00;
    wait_log(snaddr_pkg::LOG_RESTORE, 8'h30);
    `CHK("trouble gone", 1'b0, ntrb)
  endtask

  task automatic conclude();
    if (failures == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    #6_000_000;
    failures++;
    conclude();
  end

  // Reset and scenarios
  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    we = 1'b0;
    re = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    zsw = 8'h19;
    zten = 1'b1;
    drop = 8'h00;
    failures = 0;
    tests_run = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_strap();
    t_disp();
    t_decode();
    t_scan();
    t_poll();
    conclude();
  end
endmodule
`default_nettype wire

// *** sim/snaddr_partner.sv ***
`timescale 1ns/100ps
`default_nettype none
module snaddr_partner (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] drop_i,
  output logic resp_o,
  output int probes_o,
  output int rsvd_o
);
  int dly_q;
  // Present modules answer once, fast on even, slow on odd addresses
  always @(posedge clk_i)
  begin
    resp_o <= (dly_q == 1);
    if (dly_q > 0)
      dly_q <= dly_q - 1;
    if (rst_i)
    begin
      probes_o <= 0;
      rsvd_o <= 0;
      dly_q <= 0;
    end
    else if (req_i)
    begin
      probes_o <= probes_o + 1;
      if (addr_i < 8'h0a || (addr_i > 8'h0c && addr_i < 8'h10) ||
          (addr_i > 8'h3b && addr_i < 8'h40) || addr_i > 8'hfa)
        rsvd_o <= rsvd_o + 1;
      if (addr_i != 8'h0a && addr_i != 8'h31 && addr_i != drop_i)
        dly_q <= addr_i[0] ? 20 : 1;
    end
  end
endmodule
`default_nettype wire
